// >>> tsrb_bank.v
// Register bank of a digital temperature sensor: result, mode configuration,
// alarm limits and identity, reached byte by byte through a register pointer.
// Assumes a serial-bus slave on the link side presents bytes sampled on the
// rising edge of link_clk_i, and a conversion engine on clk_i.
//
// What this block does
// [RULE_01] Read-only 16-bit result register reloaded on every completed conversion.
// [RULE_02] Result left-justified, 9 to 12 or 14 bits normal, 10 to 13 or 15 extended, low bits zero.
// [RULE_03] Pointer low bits pick temp, config, lower, upper or identity register.
// [RULE_04] Configuration register is 16 bits, readable and writable.
// [RULE_05] Configuration bytes move high byte first, then low byte.
// [RULE_06] Each received byte is committed at once, not per whole word.
// [RULE_07] Bit 15 picks continuous conversion at 0, single-shot at 1.
// [RULE_08] Bits 14:13 set 9 to 12 bit resolution when fine step is off.
// [RULE_09] Bit 1 fine step forces 14-bit resolution when set; default 0.
// [RULE_10] Bits 12:11 set consecutive faults for alert: 1, 2, 4 or 6; this block only passes the field out on fault_count_o.
// [RULE_11] Bit 10 makes the limit flag active low at 0, high at 1.
// [RULE_12] Bit 8 at 0 stops paced conversions, at 1 paces them continuously while bit 15 is 0.
// [RULE_13] Bits 7:6 pace conversions at 0.25, 1, 4 or 8 Hz.
// [RULE_14] Read-only bit 5 limit flag reports alert, level follows flag sense.
// [RULE_15] Bit 4 selects normal or extended range data formats.
// [RULE_16] Configuration loads its power-up pattern; only the flag bit is read-only.
// [RULE_17] Limits are 16-bit read/write in the same format as the result.
// [RULE_18] Each conversion end compares result with both limits, updates flag.
// [RULE_19] Limit bytes move high byte first, then low byte.
// [RULE_20] Upper limit powers up at 80 degrees, lower at 75 degrees.
// [RULE_21] Identity register holds a fixed constant and ignores writes.
// [RULE_22] Writes to read-only registers or flag bit change nothing yet complete.
`timescale 1ns/1ns
`default_nettype none
`include "tsrb_defines.vh"

module tsrb_bank #(
	parameter [15:0] ID_VAL    = 16'h5a5a, // Arbitrary identity value
	parameter [26:0] PER_RATE0 = `TSRB_PER_RATE0_MS * `TSRB_CLK_KHZ,
	parameter [26:0] PER_RATE1 = `TSRB_PER_RATE1_MS * `TSRB_CLK_KHZ,
	parameter [26:0] PER_RATE2 = `TSRB_PER_RATE2_MS * `TSRB_CLK_KHZ,
	parameter [26:0] PER_RATE3 = `TSRB_PER_RATE3_MS * `TSRB_CLK_KHZ
) (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        link_clk_i,
	input  wire        ptr_wr_i,
	input  wire        byte_wr_i,
	input  wire        rd_next_i,
	input  wire [7:0]  wr_byte_i,
	input  wire        conv_done_i,
	input  wire [15:0] conv_temp_i,
	output reg  [7:0]  rd_byte_o,
	output reg         conv_start_o,
	output reg         limit_flag_o,
	output reg  [1:0]  fault_count_o,
	output reg         extended_range_o,
	output reg  [3:0]  resolution_o
);

	// ==========================================================
	// Link input synchronisers
	// Every link input shares the same two-stage delay, so the sampled byte
	// lines up with the sampled clock edge.
	reg  [11:0] sync1_q;
	reg  [11:0] sync2_q;
	reg         link_clk_prev_q;
	wire        link_rise;
	wire        ptr_wr_s;
	wire        byte_wr_s;
	wire        rd_next_s;
	wire [7:0]  wr_byte_s;

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sync1_q         <= 12'h000;
			sync2_q         <= 12'h000;
			link_clk_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q         <= {link_clk_i, ptr_wr_i, byte_wr_i, rd_next_i, wr_byte_i};
			sync2_q         <= sync1_q;
			link_clk_prev_q <= sync2_q[11];
		end
	end

	assign link_rise = sync2_q[11] & ~link_clk_prev_q;
	assign ptr_wr_s  = sync2_q[10];
	assign byte_wr_s = sync2_q[9];
	assign rd_next_s = sync2_q[8];
	assign wr_byte_s = sync2_q[7:0];

	// ==========================================================
	// Pointer and byte index
	reg  [2:0]  ptr_q;
	reg         lo_sel_q;
	wire        do_ptr;
	wire        do_wr;
	wire        do_rd;

	assign do_ptr = link_rise & ptr_wr_s;
	assign do_wr  = link_rise & byte_wr_s & ~ptr_wr_s;
	assign do_rd  = link_rise & rd_next_s & ~ptr_wr_s & ~byte_wr_s;

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ptr_q    <= `TSRB_PTR_TEMP;
			lo_sel_q <= 1'b0;
		end
		else if (do_ptr)
		begin
			ptr_q    <= wr_byte_s[2:0]; // RULE_03
			lo_sel_q <= 1'b0;
		end
		else if (do_wr || do_rd)
			lo_sel_q <= ~lo_sel_q; // RULE_05 RULE_19
	end

	// ==========================================================
	// Writable registers
	wire [15:0] cfg_q;
	wire [15:0] high_q;
	wire [15:0] low_q;
	wire        wr_hi;
	wire        wr_lo;

	assign wr_hi = do_wr & ~lo_sel_q;
	assign wr_lo = do_wr & lo_sel_q;

	// Result and identity selections have no write path at all
	tsrb_word_reg #(
		.RESET_VAL (`TSRB_CFG_RESET) // RULE_16
	) u_cfg (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.we_hi_i   (wr_hi & (ptr_q == `TSRB_PTR_CFG)), // RULE_04 RULE_06
		.we_lo_i   (wr_lo & (ptr_q == `TSRB_PTR_CFG)), // RULE_06
		.wdata_i   (wr_byte_s),
		.q_o       (cfg_q)
	);

	tsrb_word_reg #(
		.RESET_VAL (`TSRB_HIGH_RESET) // RULE_20
	) u_high (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.we_hi_i   (wr_hi & (ptr_q == `TSRB_PTR_HIGH)), // RULE_17 RULE_06
		.we_lo_i   (wr_lo & (ptr_q == `TSRB_PTR_HIGH)),
		.wdata_i   (wr_byte_s),
		.q_o       (high_q)
	);

	tsrb_word_reg #(
		.RESET_VAL (`TSRB_LOW_RESET) // RULE_20
	) u_low (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.we_hi_i   (wr_hi & (ptr_q == `TSRB_PTR_LOW)), // RULE_17 RULE_06
		.we_lo_i   (wr_lo & (ptr_q == `TSRB_PTR_LOW)),
		.wdata_i   (wr_byte_s),
		.q_o       (low_q)
	);

	// ==========================================================
	// Configuration decode
	wire        one_shot_select;
	wire [1:0]  width_sel;
	wire        flag_sense;
	wire        power_down_ctrl;
	wire [1:0]  sample_rate;
	wire        extended_range_select;
	wire        fine_step_select;

	assign one_shot_select       = cfg_q[`TSRB_CFG_ONE_SHOT];
	assign width_sel             = {cfg_q[`TSRB_CFG_WIDTH_HI], cfg_q[`TSRB_CFG_WIDTH_LO]};
	assign flag_sense            = cfg_q[`TSRB_CFG_FLAG_SENSE];
	assign power_down_ctrl       = cfg_q[`TSRB_CFG_POWER];
	assign sample_rate           = {cfg_q[`TSRB_CFG_RATE_HI], cfg_q[`TSRB_CFG_RATE_LO]};
	assign extended_range_select = cfg_q[`TSRB_CFG_EXT_RANGE];
	assign fine_step_select      = cfg_q[`TSRB_CFG_FINE_STEP];

	// Bits kept in the result for the current mode
	function [3:0] res_bits;
		input [1:0] wsel;
		input       fine;
		input       ext;
		begin
			if (fine)
				res_bits = 4'he; // RULE_09
			else
				res_bits = 4'h9 + {2'b00, wsel}; // RULE_08
			if (ext)
				res_bits = res_bits + 4'h1; // RULE_15
		end
	endfunction

	// Clears the low bits below the kept width
	function [15:0] keep_mask;
		input [3:0] nbits;
		begin
			keep_mask = 16'hffff << (5'h10 - {1'b0, nbits});
		end
	endfunction

	wire [3:0]  cur_bits;
	assign cur_bits = res_bits(width_sel, fine_step_select, extended_range_select);

	// ==========================================================
	// Result register and limit comparison
	// The fault-count queue lives in the comparator outside; here the flag
	// follows each single comparison and only the count is handed out.
	reg  [15:0] temp_q;
	reg         alert_q;
	wire [15:0] conv_masked;

	assign conv_masked = conv_temp_i & keep_mask(cur_bits); // RULE_02

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			temp_q  <= `TSRB_TEMP_RESET;
			alert_q <= 1'b0;
		end
		else if (conv_done_i)
		begin
			temp_q <= conv_masked; // RULE_01
			if ($signed(conv_masked) >= $signed(high_q))
				alert_q <= 1'b1; // RULE_18
			else if ($signed(conv_masked) < $signed(low_q))
				alert_q <= 1'b0; // RULE_18
		end
	end

	// Polarity applied to the stored alert state
	wire        flag_bit;
	assign flag_bit = flag_sense ? alert_q : ~alert_q; // RULE_11 RULE_14

	// ==========================================================
	// Conversion pacing
	reg  [26:0] pace_cnt_q;
	reg  [26:0] period;
	wire        pace_end;
	wire        one_shot_go;

	always @*
	begin
		case (sample_rate) // RULE_13
			2'b00:   period = PER_RATE0;
			2'b01:   period = PER_RATE1;
			2'b10:   period = PER_RATE2;
			default: period = PER_RATE3;
		endcase
	end

	assign pace_end = (pace_cnt_q >= period - 27'h1);
	// A high-byte write with the single-shot bit set starts one conversion
	assign one_shot_go = wr_hi & (ptr_q == `TSRB_PTR_CFG) & wr_byte_s[7];

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pace_cnt_q   <= 27'h0;
			conv_start_o <= 1'b0;
		end
		else
		begin
			conv_start_o <= 1'b0;
			if (!power_down_ctrl || one_shot_select) // RULE_12 RULE_07
				pace_cnt_q <= 27'h0;
			else if (pace_end)
			begin
				pace_cnt_q   <= 27'h0;
				conv_start_o <= 1'b1; // RULE_13
			end
			else
				pace_cnt_q <= pace_cnt_q + 27'h1;
			if (one_shot_go)
				conv_start_o <= 1'b1; // RULE_07
		end
	end

	// ==========================================================
	// Read path
	reg  [15:0] rd_word;

	always @*
	begin
		case (ptr_q) // RULE_03
			`TSRB_PTR_TEMP: rd_word = temp_q; // RULE_01 RULE_22
			`TSRB_PTR_CFG:  rd_word = {cfg_q[15:6], flag_bit, cfg_q[4:0]}; // RULE_14 RULE_22
			`TSRB_PTR_LOW:  rd_word = low_q;
			`TSRB_PTR_HIGH: rd_word = high_q;
			`TSRB_PTR_ID:   rd_word = ID_VAL; // RULE_21 RULE_22
			default:        rd_word = 16'h0000;
		endcase
	end

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rd_byte_o        <= 8'h00;
			limit_flag_o     <= 1'b1;
			fault_count_o    <= 2'h0;
			extended_range_o <= 1'b0;
			resolution_o     <= 4'hc;
		end
		else
		begin
			rd_byte_o        <= lo_sel_q ? rd_word[7:0] : rd_word[15:8]; // RULE_05 RULE_19
			limit_flag_o     <= flag_bit;
			fault_count_o    <= {cfg_q[`TSRB_CFG_FAULT_HI], cfg_q[`TSRB_CFG_FAULT_LO]}; // RULE_10
			extended_range_o <= extended_range_select;
			resolution_o     <= cur_bits;
		end
	end

endmodule

`default_nettype wire

// >>> tsrb_defines.vh
// Constants for the temperature sensor register bank.
// Assumes inclusion by bare name from the bank module only, not the word register.
`ifndef TSRB_DEFINES_VH
`define TSRB_DEFINES_VH

// ==========================================================
// Register select codes (low three bits of the pointer byte)
`define TSRB_PTR_TEMP        3'h0
`define TSRB_PTR_CFG         3'h1
`define TSRB_PTR_LOW         3'h2
`define TSRB_PTR_HIGH        3'h3
`define TSRB_PTR_ID          3'h7

// ==========================================================
// Mode configuration field positions
`define TSRB_CFG_ONE_SHOT    15
`define TSRB_CFG_WIDTH_HI    14
`define TSRB_CFG_WIDTH_LO    13
`define TSRB_CFG_FAULT_HI    12
`define TSRB_CFG_FAULT_LO    11
`define TSRB_CFG_FLAG_SENSE  10
`define TSRB_CFG_POWER       8
`define TSRB_CFG_RATE_HI     7
`define TSRB_CFG_RATE_LO     6
`define TSRB_CFG_LIMIT_FLAG  5
`define TSRB_CFG_EXT_RANGE   4
`define TSRB_CFG_FINE_STEP   1

// ==========================================================
// Power-up values
`define TSRB_CFG_RESET       16'h60a0
`define TSRB_HIGH_RESET      16'h5000
`define TSRB_LOW_RESET       16'h4b00
`define TSRB_TEMP_RESET      16'h0000

// ==========================================================
// Conversion pacing: periods in milliseconds, clock in kHz
// Sized at the pacing counter width so the products need no truncation
`define TSRB_CLK_KHZ         27'h61a8
`define TSRB_PER_RATE0_MS    27'hfa0
`define TSRB_PER_RATE1_MS    27'h3e8
`define TSRB_PER_RATE2_MS    27'hfa
`define TSRB_PER_RATE3_MS    27'h7d

`endif

// >>> tsrb_word_reg.v
// One 16-bit register written a byte at a time, high byte and low byte apart.
// Assumes byte strobes are one-cycle pulses on clk_i.
`timescale 1ns/1ns
`default_nettype none

module tsrb_word_reg #(
	parameter [15:0] RESET_VAL = 16'h0000
) (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        we_hi_i,
	input  wire        we_lo_i,
	input  wire [7:0]  wdata_i,
	output reg  [15:0] q_o
);

	// ==========================================================
	// Storage
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			q_o <= RESET_VAL;
		else
		begin
			if (we_hi_i)
				q_o[15:8] <= wdata_i;
			if (we_lo_i)
				q_o[7:0] <= wdata_i;
		end
	end

endmodule

`default_nettype wire

// >>> tsrb_chk.sv
// Port checker for the temperature sensor register bank.
// Assumes one clk_i domain and the asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module tsrb_chk (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       ptr_wr_i,
	input wire logic       byte_wr_i,
	input wire logic       rd_next_i,
	input wire logic       conv_done_i,
	input wire logic [7:0] rd_byte_o,
	input wire logic       conv_start_o,
	input wire logic       limit_flag_o,
	input wire logic [1:0] fault_count_o,
	input wire logic       extended_range_o,
	input wire logic [3:0] resolution_o
);
	logic [3:0] act_age_q;
	logic [3:0] wr_age_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// =====
	// Activity ages: outputs may only move shortly after a cause
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			act_age_q <= 4'hf;
			wr_age_q  <= 4'hf;
		end
		else
		begin
			act_age_q <= (ptr_wr_i | byte_wr_i | rd_next_i | conv_done_i) ? 4'h0
				: act_age_q + {3'h0, act_age_q != 4'hf};
			wr_age_q  <= byte_wr_i ? 4'h0 : wr_age_q + {3'h0, wr_age_q != 4'hf};
		end
	end
	// =====
	// Properties
	sequence gap_s;
		!conv_start_o [*4];
	endsequence
	AST_RESET_VALS: assert property ($rose(rst_n_i) |-> rd_byte_o == 8'h00 && limit_flag_o
		&& resolution_o == 4'hc && fault_count_o == 2'h0 && !extended_range_o)
		else $error("reset values wrong");
	AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
		else $error("start pulse too long");
	AST_START_GAP: assert property (conv_start_o |=> gap_s)
		else $error("start pulses too close");
	AST_RES_RANGE: assert property (resolution_o >= 4'h9 && resolution_o <= 4'hf)
		else $error("resolution out of range");
	AST_EXT_RES: assert property (extended_range_o |-> resolution_o inside {4'ha, 4'hb, 4'hc, 4'hd, 4'hf})
		else $error("extended mode width wrong");
	AST_NORM_RES: assert property (!extended_range_o |-> resolution_o inside {4'h9, 4'ha, 4'hb, 4'hc, 4'he})
		else $error("normal mode width wrong");
	AST_CFG_BY_WRITE: assert property ($changed({fault_count_o, extended_range_o, resolution_o})
		|-> wr_age_q < 4'hc)
		else $error("mode outputs moved without a write");
	AST_FLAG_CAUSE: assert property ($changed(limit_flag_o) |-> act_age_q < 4'hc)
		else $error("flag moved without a cause");
	AST_RD_CAUSE: assert property ($changed(rd_byte_o) |-> act_age_q < 4'hc)
		else $error("read byte moved without a cause");
endmodule
bind tsrb_bank tsrb_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ptr_wr_i(ptr_wr_i),
	.byte_wr_i(byte_wr_i), .rd_next_i(rd_next_i), .conv_done_i(conv_done_i),
	.rd_byte_o(rd_byte_o), .conv_start_o(conv_start_o), .limit_flag_o(limit_flag_o),
	.fault_count_o(fault_count_o), .extended_range_o(extended_range_o),
	.resolution_o(resolution_o));
`default_nettype wire

// >>> tsrb_link_model.sv
// Link-side model: pointer, data and read-advance bytes on a slow link clock.
// Assumes the bank samples the link on clk_i; the link clock idles low.
`timescale 1ns/1ns
`default_nettype none
module tsrb_link_model (
	input  wire logic       clk_i,
	output logic            link_clk_o,
	output logic            ptr_wr_o,
	output logic            byte_wr_o,
	output logic            rd_next_o,
	output logic [7:0]      wr_byte_o
);
	initial
	begin
		link_clk_o = 1'b0;
		ptr_wr_o   = 1'b0;
		byte_wr_o  = 1'b0;
		rd_next_o  = 1'b0;
		wr_byte_o  = 8'h00;
	end
	// =====
	// Kind 1 pointer, 2 data byte, 3 read advance; 520 ns per transfer, link clock high 160 ns
	task automatic xfer(input logic [1:0] k, input logic [7:0] b);
		@(posedge clk_i);
		ptr_wr_o  <= (k == 2'h1);
		byte_wr_o <= (k == 2'h2);
		rd_next_o <= (k == 2'h3);
		wr_byte_o <= b;
		repeat (4) @(posedge clk_i);
		link_clk_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		link_clk_o <= 1'b0;
		repeat (4) @(posedge clk_i);
		ptr_wr_o  <= 1'b0;
		byte_wr_o <= 1'b0;
		rd_next_o <= 1'b0;
		// Released byte is inverted so a stale value cannot pass
		wr_byte_o <= ~b;
	endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Testbench for the register bank, driven through the link-side model.
// Assumes small pacing periods so rate checks stay short.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [15:0] ID = 16'h3c3c; // Arbitrary identity value
	localparam int PER [4] = '{40, 20, 10, 5};
	logic [15:0] cfgs [7] = '{16'h000d, 16'h2800, 16'h5000, 16'h7800, 16'h0002,
		16'h0812, 16'h1010};
	int          res [7]  = '{9, 10, 11, 12, 14, 15, 10};
	logic        clk_i, rst_n_i, conv_done_i;
	logic [15:0] conv_temp_i;
	wire logic   link_clk, ptr_wr, byte_wr, rd_next, conv_start, limit_flag, ext_range;
	wire logic [7:0] wr_byte, rd_byte;
	wire logic [1:0] fault_count;
	wire logic [3:0] resolution;
	int          err_total, n_compared, cyc, n_start;
	tsrb_link_model u_link (.clk_i(clk_i), .link_clk_o(link_clk), .ptr_wr_o(ptr_wr),
		.byte_wr_o(byte_wr), .rd_next_o(rd_next), .wr_byte_o(wr_byte));
	tsrb_bank #(.ID_VAL(ID), .PER_RATE0(27'd40), .PER_RATE1(27'd20), .PER_RATE2(27'd10),
		.PER_RATE3(27'd5)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk),
		.ptr_wr_i(ptr_wr), .byte_wr_i(byte_wr), .rd_next_i(rd_next), .wr_byte_i(wr_byte),
		.conv_done_i(conv_done_i), .conv_temp_i(conv_temp_i), .rd_byte_o(rd_byte),
		.conv_start_o(conv_start), .limit_flag_o(limit_flag), .fault_count_o(fault_count),
		.extended_range_o(ext_range), .resolution_o(resolution));
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cyc++;
		if (conv_start === 1'b1)
			n_start++;
		if (cyc == 20000)
		begin
			err_total++;
			results();
		end
	end
	// =====
	// Tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] p, input logic [15:0] v);
		u_link.xfer(2'h1, {5'h00, p});
		u_link.xfer(2'h2, v[15:8]);
		u_link.xfer(2'h2, v[7:0]);
	endtask
	task automatic rd(input logic [2:0] p, input logic [15:0] e);
		u_link.xfer(2'h1, {5'h00, p});
		repeat (4) @(negedge clk_i);
		chk({8'h00, rd_byte}, {8'h00, e[15:8]});
		u_link.xfer(2'h3, 8'h00);
		repeat (4) @(negedge clk_i);
		chk({8'h00, rd_byte}, {8'h00, e[7:0]});
	endtask
	task automatic conv(input logic [15:0] t);
		@(posedge clk_i);
		conv_done_i <= 1'b1;
		conv_temp_i <= t;
		@(posedge clk_i);
		conv_done_i <= 1'b0;
		repeat (3) @(negedge clk_i);
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// =====
	// Main sequence
	initial
	begin
		rst_n_i = 1'b0;
		conv_done_i = 1'b0;
		conv_temp_i = 16'h0000;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(3'h0, 16'h0000);
		rd(3'h1, 16'h60a0);
		rd(3'h2, 16'h4b00);
		rd(3'h3, 16'h5000);
		rd(3'h7, ID);
		rd(3'h5, 16'h0000);
		for (int i = 0; i < 7; i++)
		begin
			wr(3'h1, cfgs[i]);
			repeat (4) @(negedge clk_i);
			chk(16'(resolution), 16'(res[i]));
			chk(16'(fault_count), 16'(cfgs[i][12:11]));
			chk(16'(ext_range), 16'(cfgs[i][4]));
			rd(3'h1, cfgs[i] | 16'h0020);
		end
		wr(3'h1, 16'h6020);
		conv(16'h5123);
		chk(16'(limit_flag), 16'h0000);
		rd(3'h0, 16'h5120);
		rd(3'h1, 16'h6000);
		wr(3'h1, 16'h6400);
		repeat (4) @(negedge clk_i);
		chk(16'(limit_flag), 16'h0001);
		conv(16'h4000);
		chk(16'(limit_flag), 16'h0000);
		wr(3'h3, 16'h1230);
		rd(3'h3, 16'h1230);
		wr(3'h2, 16'h0ff0);
		rd(3'h2, 16'h0ff0);
		conv(16'h1300);
		chk(16'(limit_flag), 16'h0001);
		wr(3'h1, 16'h0002);
		conv(16'h1237);
		rd(3'h0, 16'h1234);
		u_link.xfer(2'h1, 8'h01);
		u_link.xfer(2'h2, 8'h78);
		rd(3'h1, 16'h7802);
		wr(3'h0, 16'hffff);
		wr(3'h7, 16'h0000);
		rd(3'h0, 16'h1234);
		rd(3'h7, ID);
		for (int r = 0; r < 4; r++)
		begin
			wr(3'h1, {8'h01, 2'(r), 6'h00});
			@(negedge clk_i);
			n_start = 0;
			repeat (200) @(negedge clk_i);
			chk(16'(n_start >= 200 / PER[r] - 1 && n_start <= 200 / PER[r] + 1), 16'h1);
		end
		wr(3'h1, 16'h0000);
		@(negedge clk_i);
		n_start = 0;
		repeat (100) @(negedge clk_i);
		chk(16'(n_start), 16'h0000);
		wr(3'h1, 16'h8000);
		repeat (4) @(negedge clk_i);
		chk(16'(n_start), 16'h0001);
		results();
	end
endmodule
`default_nettype wire
